// *** bench/plb_pin_model.sv ***
// Board-side driver of the two global clock pins
module plb_pin_model
(
   input wire logic mclk,
   input wire logic rst_b,
   input wire logic [1:0] go,
   output logic pin_a,
   output logic pin_b,
   output logic busy
);
   timeunit 1ns;
   timeprecision 1ps;
   int cnt = 0;
   logic [1:0] sel = 2'h0;
   // Three cycles high then three low, pins stand low between pulses
   assign pin_a = sel[0] && cnt > 3;
   assign pin_b = sel[1] && cnt > 3;
   assign busy = cnt != 0;
   always @(posedge mclk)
   begin
      if (!rst_b)
         cnt <= 0;
      else if (cnt != 0)
         cnt <= cnt - 1;
      else if (go != 2'h0)
      begin
         cnt <= 6;
         sel <= go;
      end
   end
endmodule

// *** bench/test_plb_device.sv ***
// Self-checking bench for the logic block device with a reference model
module test_plb_device
   import plb_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int MC = 32;
   localparam logic [71:0] B33 = 72'h200000000200000000;
   localparam logic [71:0] B34 = 72'h400000000400000000;
   logic mclk = 1'h0;
   logic rst_b = 1'h0;
   logic [71:0] routing_in = '0;
   logic global_clear_pin_low = 1'h1;
   logic [1:0] global_oe_pin_low = 2'h3;
   logic [MC-1:0] fast_pin = '0;
   logic [MC*PLB_PT_PER_MC*PLB_LIT_W-1:0] cfg_pt_mask = '0;
   logic [MC*PLB_PT_PER_MC*PLB_ROUTE_W-1:0] cfg_pt_route = '0;
   logic [2*MC-1:0] cfg_ff_type = '0;
   logic [2*MC-1:0] cfg_clk_src = '0;
   logic [2*MC-1:0] cfg_borrow = '0;
   logic [MC-1:0] cfg_gclk_idx = '0;
   logic [MC-1:0] cfg_bypass = '0;
   logic [MC-1:0] cfg_use_gclr = 32'hffff0000;
   logic [MC-1:0] cfg_fast_in = '0;
   logic [MC-1:0] cfg_sum_inv = '0;
   logic [1:0] cfg_gclk_pin_sel = 2'h2;
   logic [1:0] cfg_gclk_inv = 2'h2;
   logic [1:0] go = 2'h0;
   logic global_clock_pin_a;
   logic global_clock_pin_b;
   logic busy;
   logic [MC-1:0] mc_out;
   logic [MC-1:0] shared_exp;
   logic [3:0] ded_to_routing;
   logic [1:0] global_oe;
   logic [MC*PLB_PT_PER_MC*PLB_LIT_W-1:0] tm;
   logic [MC*PLB_PT_PER_MC*PLB_ROUTE_W-1:0] tr;
   logic [MC-1:0] qm = '0;
   logic [31:0] lfsr = 32'h00012adc;
   logic [95:0] rv;
   int n_mismatch = 0;
   int n_compared = 0;
   int cycles = 0;

   plb_device #(.MC_COUNT(MC), .ENHANCED(1'b1)) dut_u (
      .mclk, .rst_b, .routing_in, .global_clock_pin_a, .global_clock_pin_b,
      .global_clear_pin_low, .global_oe_pin_low, .fast_pin, .cfg_pt_mask, .cfg_pt_route,
      .cfg_ff_type, .cfg_clk_src, .cfg_gclk_idx, .cfg_bypass, .cfg_use_gclr, .cfg_fast_in,
      .cfg_sum_inv, .cfg_borrow, .cfg_gclk_pin_sel, .cfg_gclk_inv, .mc_out, .shared_exp,
      .ded_to_routing, .global_oe
   );
   plb_pin_model pins_u (
      .mclk(mclk), .rst_b(rst_b), .go(go), .pin_a(global_clock_pin_a),
      .pin_b(global_clock_pin_b), .busy(busy)
   );

   always #5 mclk = ~mclk;

   function automatic logic [31:0] lfsr_next(logic [31:0] s);
      for (int k = 0; k < 32; k++)
         s = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
      return s;
   endfunction

   task automatic complete_run();
      $display("compared %0d, mismatched %0d", n_compared, n_mismatch);
      if (n_mismatch == 0 && n_compared > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask

   always @(posedge mclk)
   begin
      cycles++;
      if (cycles == 5000)
      begin
         n_mismatch++;
         complete_run();
      end
   end

   task automatic check(logic [63:0] got, logic [63:0] exp, string what);
      n_compared++;
      if (got !== exp)
      begin
         n_mismatch++;
         $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask

   task automatic roll();
      for (int k = 0; k < 3; k++)
      begin
         lfsr = lfsr_next(lfsr);
         rv[k*32+:32] = lfsr;
      end
   endtask

   task automatic set_term(int i, int p, int lit, plb_pt_route_t rt);
      int n;
      n = i * PLB_PT_PER_MC + p;
      tr[n*PLB_ROUTE_W+:PLB_ROUTE_W] = rt;
      // A literal and its complement together give a term that is always 0
      if (lit < 0)
         tm[n*PLB_LIT_W+PLB_SRC_W] = 1'h1;
      tm[n*PLB_LIT_W+(lit < 0 ? 0 : lit)] = 1'h1;
   endtask

   task automatic set_cfg(int mode);
      logic [2*MC-1:0] f;
      logic [2*MC-1:0] c;
      logic [2*MC-1:0] bo;
      logic [MC-1:0] gi;
      logic [MC-1:0] fi;
      logic [MC-1:0] si;
      int j;
      tm = '0;
      for (int i = 0; i < MC; i++)
      begin
         j = i % 16;
         f[2*i+:2] = i[1:0];
         c[2*i+:2] = 2'(mode % 3);
         bo[2*i+:2] = (mode == 3 && j % 8 != 0) ? 2'h1 : 2'h0;
         gi[i] = i[2];
         fi[i] = i[1:0] == 2'h0 && i[3];
         si[i] = mode == 3 && i[2];
         set_term(i, 0, j, PLB_PT_SUM);
         if (mode < 3)
         begin
            set_term(i, 1, j + 16, PLB_PT_AUX);
            set_term(i, 2, 35, PLB_PT_CEN);
            set_term(i, 3, 34, PLB_PT_ACLK);
            set_term(i, 4, 33, i[3] ? PLB_PT_PRE : PLB_PT_CLR);
         end
         else
         begin
            set_term(i, 1, 36 + (j + 1) % 16, PLB_PT_SUM);
            set_term(i, 2, j + 20, PLB_PT_LEND);
            set_term(i, 3, -1, PLB_PT_SUM);
            set_term(i, 4, j + 8, PLB_PT_SHARE);
         end
      end
      @(posedge mclk);
      cfg_pt_mask <= tm;
      cfg_pt_route <= tr;
      cfg_ff_type <= f;
      cfg_clk_src <= c;
      cfg_borrow <= bo;
      cfg_gclk_idx <= gi;
      cfg_fast_in <= fi;
      cfg_sum_inv <= si;
      cfg_bypass <= {MC{mode == 3}};
   endtask

   task automatic pulse(logic [1:0] pin);
      go <= pin;
      @(posedge mclk);
      go <= 2'h0;
      #1;
      for (int k = 0; k < 20 && busy; k++)
         @(posedge mclk);
      repeat (6) @(posedge mclk);
   endtask

   task automatic model_clock(int mode, int pin, logic [71:0] r);
      int b;
      int j;
      logic s;
      logic a;
      logic d;
      for (int i = 0; i < MC; i++)
      begin
         b = i / 16 * 36;
         j = i % 16;
         s = r[b+j];
         a = r[b+j+16];
         d = (i[1:0] == 2'h0 && i[3]) ? fast_pin[i] : s;
         if (mode == 2 || (i[2] == pin && (mode == 0 || r[b+35])))
            case (i[1:0])
               0: qm[i] = d;
               1: qm[i] = qm[i] ^ s;
               2: qm[i] = (s & ~qm[i]) | (~a & qm[i]);
               default: qm[i] = s | (~a & qm[i]);
            endcase
      end
   endtask

   task automatic clock_step(int mode, int pin);
      logic [71:0] r;
      roll();
      r = rv[71:0] & ~(B33 | B34);
      @(posedge mclk);
      routing_in <= r;
      fast_pin <= rv[95:64];
      global_oe_pin_low <= rv[1:0];
      repeat (4) @(posedge mclk);
      routing_in <= r | B34;
      pulse(pin ? 2'h2 : 2'h1);
      model_clock(mode, pin, r);
      check(mc_out, qm, "register");
      check({ded_to_routing, global_oe}, {rv[1:0], 2'h2, ~rv[1:0]}, "dedicated");
   endtask

   task automatic bypass_step();
      logic [71:0] r;
      logic [MC-1:0] e;
      logic [MC-1:0] sh;
      int b;
      int j;
      roll();
      r = rv[71:0];
      for (int i = 0; i < MC; i++)
      begin
         b = i / 16 * 36;
         j = i % 16;
         e[i] = (r[b+j] | ~r[b+8+(j+1)%16] | (j % 8 != 0 && r[b+19+j])) ^ i[2];
         sh[i] = ~r[b+8+j];
      end
      @(posedge mclk);
      routing_in <= r;
      repeat (3) @(posedge mclk);
      check(mc_out, e, "bypass sum");
      check(shared_exp, sh, "shared terms");
   endtask

   initial
   begin
      set_cfg(0);
      repeat (4) @(posedge mclk);
      check(mc_out, '0, "reset out");
      check({shared_exp, ded_to_routing, global_oe}, '0, "reset misc");
      @(posedge mclk);
      rst_b <= 1'h1;
      $display("test reset done");
      for (int m = 0; m < 3; m++)
      begin
         if (m > 0)
            set_cfg(m);
         for (int k = 0; k < 8; k++)
            clock_step(m, k % 2);
         $display("test clock mode %0d done", m);
      end
      @(posedge mclk);
      routing_in <= B33;
      repeat (6) @(posedge mclk);
      check(mc_out, 32'hff00ff00, "term preset and clear");
      routing_in <= B33 | B34;
      pulse(2'h1);
      check(mc_out, 32'hff00ff00, "async over clock");
      routing_in <= '0;
      repeat (6) @(posedge mclk);
      check(mc_out, 32'hff00ff00, "hold after release");
      global_clear_pin_low <= 1'h0;
      repeat (6) @(posedge mclk);
      check(mc_out, 32'h0000ff00, "global clear");
      global_clear_pin_low <= 1'h1;
      repeat (6) @(posedge mclk);
      check(mc_out, 32'h0000ff00, "global clear removed");
      $display("test async done");
      rst_b <= 1'h0;
      repeat (3) @(posedge mclk);
      check(mc_out, '0, "second reset");
      rst_b <= 1'h1;
      set_cfg(3);
      for (int k = 0; k < 16; k++)
         bypass_step();
      $display("test bypass and expanders done");
      complete_run();
   end
endmodule

// *** common/plb_mc_if.sv ***
// Signals between the block top and one macrocell register
interface plb_mc_if;
   import plb_pkg::*;
   plb_ff_t ff_type;
   plb_clk_src_t clk_src;
   logic sum;
   logic aux;
   logic clr;
   logic pre;
   logic cen;
   logic aclk;
   logic gtick;
   logic use_fast;
   logic fast_d;
   logic q;

   modport ctl (
      output ff_type, clk_src, sum, aux, clr, pre, cen, aclk, gtick, use_fast, fast_d,
      input q
   );
   modport regm (
      input ff_type, clk_src, sum, aux, clr, pre, cen, aclk, gtick, use_fast, fast_d,
      output q
   );
endinterface

// *** common/plb_pkg.sv ***
// Constants and types shared by the programmable logic block design
package plb_pkg;
   localparam int PLB_MC_PER_BLK = 16;
   localparam int PLB_MC_MIN = 32;
   localparam int PLB_MC_MAX = 256;
   localparam int PLB_PT_PER_MC = 5;
   localparam int PLB_ROUTE_IN = 36;
   localparam int PLB_SRC_W = PLB_ROUTE_IN + PLB_MC_PER_BLK;
   localparam int PLB_LIT_W = 2 * PLB_SRC_W;
   localparam int PLB_ROUTE_W = 3;
   localparam int PLB_CHAIN_LEN = 8;
   localparam int PLB_MAX_SETS = 3;
   localparam int PLB_BORROW_W = 2;
   localparam int PLB_NUM_GCLK = 2;
   localparam int PLB_NUM_GOE = 2;
   localparam int PLB_NUM_DED = 4;
   localparam int PLB_SYNC_STAGES = 2;
   localparam logic PLB_Q_RESET = 1'h0;
   // Literal positions that a shareable expander may use: routing inputs only
   localparam logic [PLB_LIT_W-1:0] PLB_SHARE_MASK =
      {{PLB_MC_PER_BLK{1'b0}}, {PLB_ROUTE_IN{1'b1}}, {PLB_MC_PER_BLK{1'b0}}, {PLB_ROUTE_IN{1'b1}}};

   typedef enum logic [2:0] {
      PLB_PT_SUM, PLB_PT_AUX, PLB_PT_CLR, PLB_PT_PRE,
      PLB_PT_ACLK, PLB_PT_CEN, PLB_PT_SHARE, PLB_PT_LEND
   } plb_pt_route_t;

   typedef enum logic [1:0] {PLB_FF_D, PLB_FF_T, PLB_FF_JK, PLB_FF_SR} plb_ff_t;

   typedef enum logic [1:0] {PLB_CLK_GLOBAL, PLB_CLK_GATED, PLB_CLK_ARRAY} plb_clk_src_t;
endpackage

// *** rtl/plb_device.sv ***
// Device array of logic blocks with macrocells, expanders and global controls
// Summary of operation
// - Macrocells grouped sixteen per logic block
// - Macrocell count 32 to 256, block multiple
// - Each block takes routing inputs plus global controls
// - Four dedicated pins: clock, clear, two enables
// - Five product terms per macrocell
// - Select matrix routes terms to sum or controls
// - Expanders allow up to 20 terms per macrocell
// - Shareable terms inverted and fed back in block
// - Parallel terms borrowed from neighbours into sum
// - Register works as D, T, JK or SR
// - Bypass sends combinational result to output
// - Three clock sources: global, gated, array
// - Gated mode captures only with enable high
// - Array clock comes from a product term
// - Basic one global clock; enhanced two, invertible
// - Product-term preset and clear active high
// - Optional active-low global clear per macrocell
// - All macrocell and output registers start at zero; clear and enable synchronisers at one
// - Enhanced fast pin path straight to D
// - Sixteen shareable terms per block, any user
// - Sum takes own five plus fifteen borrowed
module plb_device
   import plb_pkg::*;
#(
   parameter int MC_COUNT = PLB_MC_MIN,
   parameter bit ENHANCED = 1'b1
)
(
   input logic mclk,
   input logic rst_b,
   input logic [MC_COUNT/PLB_MC_PER_BLK*PLB_ROUTE_IN-1:0] routing_in,
   input logic global_clock_pin_a,
   input logic global_clock_pin_b,
   input logic global_clear_pin_low,
   input logic [PLB_NUM_GOE-1:0] global_oe_pin_low,
   input logic [MC_COUNT-1:0] fast_pin,
   input logic [MC_COUNT*PLB_PT_PER_MC*PLB_LIT_W-1:0] cfg_pt_mask,
   input logic [MC_COUNT*PLB_PT_PER_MC*PLB_ROUTE_W-1:0] cfg_pt_route,
   input logic [2*MC_COUNT-1:0] cfg_ff_type,
   input logic [2*MC_COUNT-1:0] cfg_clk_src,
   input logic [MC_COUNT-1:0] cfg_gclk_idx,
   input logic [MC_COUNT-1:0] cfg_bypass,
   input logic [MC_COUNT-1:0] cfg_use_gclr,
   input logic [MC_COUNT-1:0] cfg_fast_in,
   input logic [MC_COUNT-1:0] cfg_sum_inv,
   input logic [PLB_BORROW_W*MC_COUNT-1:0] cfg_borrow,
   input logic [PLB_NUM_GCLK-1:0] cfg_gclk_pin_sel,
   input logic [PLB_NUM_GCLK-1:0] cfg_gclk_inv,
   output logic [MC_COUNT-1:0] mc_out,
   output logic [MC_COUNT/PLB_MC_PER_BLK*PLB_MC_PER_BLK-1:0] shared_exp,
   output logic [PLB_NUM_DED-1:0] ded_to_routing,
   output logic [PLB_NUM_GOE-1:0] global_oe
);
   localparam int NBLK = MC_COUNT / PLB_MC_PER_BLK;

   // Pin synchronisers, first stage read only by the second
   logic [PLB_SYNC_STAGES-1:0] clka_sync_reg;
   logic [PLB_SYNC_STAGES-1:0] clkb_sync_reg;
   logic [PLB_SYNC_STAGES-1:0] gclr_sync_reg;
   logic [PLB_NUM_GOE-1:0] goe_meta_reg;
   logic [PLB_NUM_GOE-1:0] goe_sync_reg;
   logic [MC_COUNT-1:0] fast_meta_reg;
   logic [MC_COUNT-1:0] fast_sync_reg;

   logic clka_s;
   logic clkb_s;
   logic gclr_active;
   logic [PLB_NUM_GCLK-1:0] gclk_lvl;
   logic [PLB_NUM_GCLK-1:0] gclk_prev_reg;
   logic [PLB_NUM_GCLK-1:0] gclk_tick;

   logic [MC_COUNT-1:0] sum_own;
   logic [MC_COUNT-1:0] aux_pt;
   logic [MC_COUNT-1:0] clr_pt;
   logic [MC_COUNT-1:0] pre_pt;
   logic [MC_COUNT-1:0] aclk_pt;
   logic [MC_COUNT-1:0] cen_pt;
   logic [MC_COUNT-1:0] lend_raw;
   logic [MC_COUNT-1:0] lend;
   logic [MC_COUNT-1:0] borrowed;
   logic [MC_COUNT-1:0] sum_xor;
   logic [MC_COUNT-1:0] share_raw;
   logic [MC_COUNT-1:0] q;
   logic [MC_COUNT-1:0] mc_out_reg;
   logic [MC_COUNT-1:0] mc_out_next;
   logic [MC_COUNT-1:0] shared_exp_reg;
   logic [PLB_NUM_DED-1:0] ded_reg;
   logic [PLB_NUM_GOE-1:0] goe_reg;

   always_ff @(posedge mclk)
   begin
      if (!rst_b)
      begin
         clka_sync_reg <= '0;
         clkb_sync_reg <= '0;
         gclr_sync_reg <= '1;
         goe_meta_reg <= '1;
         goe_sync_reg <= '1;
      end
      else
      begin
         clka_sync_reg <= {clka_sync_reg[0], global_clock_pin_a};
         clkb_sync_reg <= {clkb_sync_reg[0], global_clock_pin_b};
         gclr_sync_reg <= {gclr_sync_reg[0], global_clear_pin_low};
         goe_meta_reg <= global_oe_pin_low;
         goe_sync_reg <= goe_meta_reg;
      end
   end

   always_ff @(posedge mclk)
   begin
      if (!rst_b)
      begin
         fast_meta_reg <= '0;
         fast_sync_reg <= '0;
      end
      else
      begin
         fast_meta_reg <= fast_pin;
         fast_sync_reg <= fast_meta_reg;
      end
   end

   assign clka_s = clka_sync_reg[PLB_SYNC_STAGES-1];
   assign clkb_s = clkb_sync_reg[PLB_SYNC_STAGES-1];
   assign gclr_active = ~gclr_sync_reg[PLB_SYNC_STAGES-1];

   // Global clock network: pin choice and inversion only on enhanced parts
   always_comb
   begin
      for (int j = 0; j < PLB_NUM_GCLK; j++)
      begin
         if (ENHANCED)
            gclk_lvl[j] = (cfg_gclk_pin_sel[j] ? clkb_s : clka_s) ^ cfg_gclk_inv[j];
         else
            gclk_lvl[j] = (j == 0) ? clka_s : 1'b0;
      end
   end

   // Start from the idle level of each network, so an inverted clock shows no edge at release
   always_ff @(posedge mclk)
   begin
      if (!rst_b)
         gclk_prev_reg <= gclk_lvl;
      else
         gclk_prev_reg <= gclk_lvl;
   end

   assign gclk_tick = gclk_lvl & ~gclk_prev_reg;

   // Dedicated pins also reach the routing array as plain inputs
   always_ff @(posedge mclk)
   begin
      if (!rst_b)
      begin
         ded_reg <= '0;
         goe_reg <= '0;
      end
      else
      begin
         ded_reg <= {goe_sync_reg, ~gclr_active, clka_s};
         goe_reg <= ~goe_sync_reg;
      end
   end

   for (genvar b = 0; b < NBLK; b++)
   begin : g_blk
      logic [PLB_MC_PER_BLK-1:0] blk_share;
      logic [PLB_SRC_W-1:0] blk_src;

      assign blk_share = share_raw[b*PLB_MC_PER_BLK +: PLB_MC_PER_BLK];
      assign blk_src = {blk_share, routing_in[b*PLB_ROUTE_IN +: PLB_ROUTE_IN]};

      for (genvar m = 0; m < PLB_MC_PER_BLK; m++)
      begin : g_mc
         localparam int I = b * PLB_MC_PER_BLK + m;
         localparam int POS = m % PLB_CHAIN_LEN;
         logic brw;
         plb_mc_if mc_if ();

         plb_pterm_sel u_pt (
            .lits ({~blk_src, blk_src}),
            .mask (cfg_pt_mask[I*PLB_PT_PER_MC*PLB_LIT_W +: PLB_PT_PER_MC*PLB_LIT_W]),
            .route (cfg_pt_route[I*PLB_PT_PER_MC*PLB_ROUTE_W +: PLB_PT_PER_MC*PLB_ROUTE_W]),
            .sum (sum_own[I]),
            .aux (aux_pt[I]),
            .clr (clr_pt[I]),
            .pre (pre_pt[I]),
            .aclk (aclk_pt[I]),
            .cen (cen_pt[I]),
            .lend (lend_raw[I]),
            .share (share_raw[I])
         );

         // Top of each chain of eight can only borrow
         assign lend[I] = (POS == PLB_CHAIN_LEN - 1) ? 1'b0 : lend_raw[I];

         // Borrow up to three sets from lower neighbours in the same chain
         always_comb
         begin
            brw = 1'b0;
            for (int k = 1; k <= PLB_MAX_SETS; k++)
            begin
               if (POS >= k && int'(cfg_borrow[I*PLB_BORROW_W +: PLB_BORROW_W]) >= k)
                  brw = brw | lend[I - (POS >= k ? k : 0)];
            end
         end

         assign borrowed[I] = brw;

         assign sum_xor[I] = (sum_own[I] | borrowed[I]) ^ cfg_sum_inv[I];

         assign mc_if.ff_type = plb_ff_t'(cfg_ff_type[2*I +: 2]);
         assign mc_if.clk_src = plb_clk_src_t'(cfg_clk_src[2*I +: 2]);
         assign mc_if.sum = sum_xor[I];
         assign mc_if.aux = aux_pt[I];
         assign mc_if.clr = clr_pt[I] | (cfg_use_gclr[I] & gclr_active);
         assign mc_if.pre = pre_pt[I];
         assign mc_if.cen = cen_pt[I];
         assign mc_if.aclk = aclk_pt[I];
         assign mc_if.gtick = gclk_tick[ENHANCED ? cfg_gclk_idx[I] : 1'b0];
         assign mc_if.use_fast = ENHANCED & cfg_fast_in[I];
         assign mc_if.fast_d = fast_sync_reg[I];
         assign q[I] = mc_if.q;

         plb_mc_reg u_reg (
            .mclk (mclk),
            .rst_b (rst_b),
            .mc (mc_if.regm)
         );
      end
   end

   assign mc_out_next = (cfg_bypass & sum_xor) | (~cfg_bypass & q);

   always_ff @(posedge mclk)
   begin
      if (!rst_b)
      begin
         mc_out_reg <= '0;
         shared_exp_reg <= '0;
      end
      else
      begin
         mc_out_reg <= mc_out_next;
         shared_exp_reg <= share_raw;
      end
   end

   assign mc_out = mc_out_reg;
   assign shared_exp = shared_exp_reg;
   assign ded_to_routing = ded_reg;
   assign global_oe = goe_reg;

   AST_MC_COUNT: assert property (@(posedge mclk) disable iff (!rst_b)
      MC_COUNT % PLB_MC_PER_BLK == 0 && MC_COUNT >= PLB_MC_MIN && MC_COUNT <= PLB_MC_MAX)
      else $error("macrocell count out of range");
   AST_OUT_RESET: assert property (@(posedge mclk) !rst_b |=> mc_out == '0)
      else $error("outputs not zero after reset");
   AST_BYPASS: assert property (@(posedge mclk) disable iff (!rst_b)
      cfg_bypass[0] |=> mc_out[0] == $past(sum_xor[0]))
      else $error("bypassed output does not follow sum");
   AST_GOE_PIN: assert property (@(posedge mclk) disable iff (!rst_b)
      global_oe_pin_low[0] ##1 global_oe_pin_low[0] ##1 global_oe_pin_low[0]
      |=> !global_oe[0])
      else $error("global enable ignores its pin");
   AST_GCLR: assert property (@(posedge mclk) disable iff (!rst_b)
      gclr_active && cfg_use_gclr[MC_COUNT-1]
      |=> ##1 !mc_out[MC_COUNT-1] || cfg_bypass[MC_COUNT-1])
      else $error("global clear did not reach register");
   AST_BORROW_SUM: assert property (@(posedge mclk) disable iff (!rst_b)
      cfg_borrow[3:2] != 2'h0 && lend_raw[0] && !cfg_sum_inv[1] |-> sum_xor[1])
      else $error("borrowed term did not reach neighbour sum");
   COV_BORROW_FULL: cover property (@(posedge mclk) disable iff (!rst_b)
      cfg_borrow[2*3 +: 2] == 2'h3 && borrowed[3]);
   COV_GCLK_TICK: cover property (@(posedge mclk) disable iff (!rst_b) gclk_tick[1]);
   COV_GCLR: cover property (@(posedge mclk) disable iff (!rst_b) $rose(gclr_active));
endmodule

// *** rtl/plb_mc_reg.sv ***
// Configurable macrocell register: D, T, JK or SR with three clock sources
module plb_mc_reg
   import plb_pkg::*;
(
   input logic mclk,
   input logic rst_b,
   plb_mc_if.regm mc
);
   logic q_reg;
   logic q_next;
   logic aclk_prev_reg;
   logic tick;
   logic d_in;

   always_ff @(posedge mclk)
   begin
      if (!rst_b)
         aclk_prev_reg <= 1'b0;
      else
         aclk_prev_reg <= mc.aclk;
   end

   always_comb
   begin
      unique case (mc.clk_src)
         PLB_CLK_GLOBAL: tick = mc.gtick;
         PLB_CLK_GATED: tick = mc.gtick & mc.cen;
         PLB_CLK_ARRAY: tick = mc.aclk & ~aclk_prev_reg;
         default: tick = 1'b0;
      endcase
   end

   // Fast pin path feeds D directly, skipping the sum logic
   assign d_in = mc.use_fast ? mc.fast_d : mc.sum;

   always_comb
   begin
      unique case (mc.ff_type)
         PLB_FF_D: q_next = d_in;
         PLB_FF_T: q_next = q_reg ^ mc.sum;
         PLB_FF_JK: q_next = (mc.sum & ~q_reg) | (~mc.aux & q_reg);
         PLB_FF_SR: q_next = mc.sum | (~mc.aux & q_reg);
      endcase
   end

   always_ff @(posedge mclk)
   begin
      if (!rst_b)
         q_reg <= PLB_Q_RESET;
      else if (mc.clr)
         q_reg <= 1'b0;
      else if (mc.pre)
         q_reg <= 1'b1;
      else if (tick)
         q_reg <= q_next;
   end

   assign mc.q = q_reg;

   AST_RESET_LOW: assert property (@(posedge mclk) !rst_b |=> !mc.q)
      else $error("register not low after reset");
   AST_CLR_WINS: assert property (@(posedge mclk) disable iff (!rst_b)
      mc.clr ##1 mc.clr |-> !mc.q)
      else $error("clear did not hold register low");
   AST_PRE_SET: assert property (@(posedge mclk) disable iff (!rst_b)
      mc.pre && !mc.clr |=> mc.q)
      else $error("preset did not set register");
   AST_GATED_HOLD: assert property (@(posedge mclk) disable iff (!rst_b)
      mc.clk_src == PLB_CLK_GATED && mc.gtick && !mc.cen && !mc.clr && !mc.pre
      |=> $stable(mc.q))
      else $error("gated register changed with enable low");
   AST_D_CAPTURE: assert property (@(posedge mclk) disable iff (!rst_b)
      mc.ff_type == PLB_FF_D && mc.clk_src == PLB_CLK_GATED && mc.gtick && mc.cen
      && !mc.clr && !mc.pre |=> mc.q == $past(d_in))
      else $error("D register missed its capture");
   AST_T_TOGGLE: assert property (@(posedge mclk) disable iff (!rst_b)
      mc.ff_type == PLB_FF_T && tick && mc.sum && !mc.clr && !mc.pre
      |=> mc.q != $past(mc.q))
      else $error("T register did not toggle");
   COV_ARRAY_CLK: cover property (@(posedge mclk) disable iff (!rst_b)
      mc.clk_src == PLB_CLK_ARRAY && tick);
   COV_JK_TOGGLE: cover property (@(posedge mclk) disable iff (!rst_b)
      mc.ff_type == PLB_FF_JK && tick && mc.sum && mc.aux);
endmodule

// *** rtl/plb_pterm_sel.sv ***
// Product-term array and select matrix of one macrocell
module plb_pterm_sel
   import plb_pkg::*;
#(
   parameter int LIT_W = PLB_LIT_W,
   parameter int NPT = PLB_PT_PER_MC
)
(
   input logic [LIT_W-1:0] lits,
   input logic [NPT*LIT_W-1:0] mask,
   input logic [NPT*PLB_ROUTE_W-1:0] route,
   output logic sum,
   output logic aux,
   output logic clr,
   output logic pre,
   output logic aclk,
   output logic cen,
   output logic lend,
   output logic share
);
   logic [NPT-1:0] pt;
   logic [NPT-1:0] shpt;

   // An empty mask leaves the product term at one
   for (genvar p = 0; p < NPT; p++)
   begin : g_pt
      assign pt[p] = &(lits | ~mask[p*LIT_W +: LIT_W]);
      assign shpt[p] = &(lits | ~(mask[p*LIT_W +: LIT_W] & PLB_SHARE_MASK));
   end

   always_comb
   begin
      sum = 1'b0;
      aux = 1'b0;
      clr = 1'b0;
      pre = 1'b0;
      aclk = 1'b0;
      cen = 1'b0;
      lend = 1'b0;
      share = 1'b1;
      for (int p = 0; p < NPT; p++)
      begin
         unique case (plb_pt_route_t'(route[p*PLB_ROUTE_W +: PLB_ROUTE_W]))
            PLB_PT_SUM: sum = sum | pt[p];
            PLB_PT_AUX: aux = aux | pt[p];
            PLB_PT_CLR: clr = clr | pt[p];
            PLB_PT_PRE: pre = pre | pt[p];
            PLB_PT_ACLK: aclk = aclk | pt[p];
            PLB_PT_CEN: cen = cen | pt[p];
            PLB_PT_SHARE: share = share & ~shpt[p];
            PLB_PT_LEND: lend = lend | pt[p];
         endcase
      end
   end
endmodule
